/* verilog/pdr_params.svh */
`ifndef PDR_PARAMS_SVH
`define PDR_PARAMS_SVH

// register kind codes, byte offset = kind * 8 + port index
`define PDR_KIND_DIR 5'h00
`define PDR_KIND_DRIVE 5'h01
`define PDR_KIND_CTRL 5'h02
`define PDR_KIND_PIN_IN 5'h03
`define PDR_KIND_OUT_DATA 5'h04
`define PDR_KIND_OMC 5'h05
`define PDR_KIND_MASK 5'h06
`define PDR_KIND_IMC 5'h07
`define PDR_KIND_ENOUT 5'h08

`define PDR_PORT_A 3'h0
`define PDR_PORT_B 3'h1
`define PDR_PORT_C 3'h2
`define PDR_PORT_D 3'h3
`define PDR_PORT_E 3'h4
`define PDR_PORT_F 3'h5
`define PDR_PORT_G 3'h6

`define PDR_NUM_PORTS 7
`define PDR_RESET_BYTE 8'h00
`define PDR_FULL_MASK 8'hff
`define PDR_PORT_D_MASK 8'h0f

// dedicated port d pin positions
`define PDR_PD_STROBE 0
`define PDR_PD_CLOCK 1
`define PDR_PD_CHIPSEL 2
`define PDR_PD_BYTE_EN 3
// port e battery pins
`define PDR_PE_BAT_IN 6
`define PDR_PE_BAT_FLAG 7

`endif

/* verilog/pdr_pkg.sv */
package pdr_pkg;
`include "pdr_params.svh"

    typedef logic [`PDR_NUM_PORTS-1:0][7:0] pdr_bytes_t;

    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdr_mcu_req_s;

    typedef struct packed {
        logic portAMcellOut;
        logic portBMcellOut;
        logic portCChipSelOut;
        logic portFChipSelOut;
        logic portFDataPort;
        logic pd0IsStrobe;
        logic pd1IsClock;
        logic pd2IsChipSel;
        logic pd3IsByteEn;
        logic pe6IsBattery;
        logic pe7IsBatteryFlag;
    } pdr_cfg_s;

    typedef struct packed {
        pdr_bytes_t level;
        pdr_bytes_t oe;
    } pdr_pins_s;

    typedef struct packed {
        logic [7:0] imcA;
        logic [7:0] imcB;
        logic [7:0] imcC;
        logic [7:0] mcellA;
        logic [7:0] mcellB;
        logic [3:0] portD;
        logic [7:0] portF;
    } pdr_pld_in_s;

    typedef struct packed {
        pdr_bytes_t dir;
        pdr_bytes_t drive;
        pdr_bytes_t ctrl;
        pdr_bytes_t outData;
        logic [2:0][7:0] input_macrocell;
        logic [1:0][7:0] mask;
        logic [7:0] addrLatch;
        logic clkPrev;
        logic [7:0] rdData;
        logic rdValid;
    } pdr_top_state_s;

    typedef struct packed {
        logic [7:0] q;
    } pdr_bank_state_s;
endpackage

/* verilog/pdr_pin_driver.sv */
`timescale 1ns/1ps
module pdr_pin_driver #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] dataOut,
    input wire logic [WIDTH-1:0] altData,
    input wire logic [WIDTH-1:0] altSel,
    input wire logic [WIDTH-1:0] dirBits,
    input wire logic [WIDTH-1:0] oeTerm,
    input wire logic [WIDTH-1:0] openDrain,
    output logic [WIDTH-1:0] pinLevel,
    output logic [WIDTH-1:0] pinOe,
    output logic [WIDTH-1:0] enableStatus
);
    logic [WIDTH-1:0] active;
    logic [WIDTH-1:0] level;

    always_comb begin
        active = dirBits | oeTerm;
        level = (altSel & altData) | (~altSel & dataOut);
        // open drain only sinks; a high is left to the pull-up
        pinOe = active & (openDrain | ~openDrain & {WIDTH{1'b1}})
            & ~(openDrain & level);
        pinLevel = level & ~openDrain;
        enableStatus = active;
    end
endmodule

/* verilog/pdr_macrocell_bank.sv */
`timescale 1ns/1ps
module pdr_macrocell_bank (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clockTick,
    input wire logic [7:0] pldNext,
    input wire logic mcuLoad,
    input wire logic [7:0] mcuData,
    input wire logic [7:0] loadMask,
    output logic [7:0] q
);
    import pdr_pkg::*;

    pdr_bank_state_s state;
    pdr_bank_state_s next_state;

    always_comb begin
        next_state = state;
        if (clockTick) begin
            next_state.q = pldNext;
        end
        // mcu load wins over the array on a shared cycle, except masked bits, which take the array value
        if (mcuLoad) begin
            next_state.q = (mcuData & ~loadMask)
                | (next_state.q & loadMask);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            next_state_reset: state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign q = state.q;
endmodule

/* verilog/pdr_port.sv */
`timescale 1ns/1ps
`include "pdr_params.svh"
module pdr_port (
    input wire logic core_clk,
    input wire logic resetn,
    input wire pdr_pkg::pdr_mcu_req_s mcuReq,
    output logic [7:0] mcuRdData,
    output logic mcuRdValid,
    input wire pdr_pkg::pdr_cfg_s cfg,
    input wire pdr_pkg::pdr_bytes_t pinIn,
    output pdr_pkg::pdr_pins_s pinDrv,
    input wire pdr_pkg::pdr_bytes_t pldOeTerm,
    input wire logic [7:0] pldMcellNextA,
    input wire logic [7:0] pldMcellNextB,
    input wire logic [7:0] chipSelects,
    input wire logic [7:0] hostAddrLow,
    input wire logic [7:0] hostDataOut,
    input wire logic hostDataOe,
    input wire logic vccBelowBattery,
    output pdr_pkg::pdr_pld_in_s pldInputBus,
    output logic [7:0] hostDataIn,
    output logic addressStrobe,
    output logic dataByteEnable,
    output logic commonClockTick,
    output logic memSpaceEnable,
    output logic [7:0] slewFastC,
    output logic [7:0] slewFastF
);
    import pdr_pkg::*;

    pdr_top_state_s state;
    pdr_top_state_s next_state;

    logic [4:0] kind;
    logic [2:0] port;
    logic accessOk;
    logic regPresent;
    logic wrOk;
    logic omcLoadA;
    logic omcLoadB;
    logic [7:0] mcellA;
    logic [7:0] mcellB;
    logic [7:0] readValue;
    logic [7:0] batMask;
    pdr_bytes_t altData;
    pdr_bytes_t altSel;
    pdr_bytes_t dirEff;
    pdr_bytes_t oeEff;
    pdr_bytes_t openDrainEff;
    pdr_bytes_t dataEff;
    pdr_bytes_t enStatus;
    pdr_bytes_t drvLevel;
    pdr_bytes_t drvOe;

    // port d has only four pins
    function automatic logic [7:0] portMask(input logic [2:0] p);
        if (p == `PDR_PORT_D) begin
            portMask = `PDR_PORT_D_MASK;
        end else begin
            portMask = `PDR_FULL_MASK;
        end
    endfunction

    function automatic logic regExists(input logic [4:0] k,
                                       input logic [2:0] p);
        logic anyPort;
        logic ab;
        anyPort = (p <= `PDR_PORT_G);
        ab = (p == `PDR_PORT_A) || (p == `PDR_PORT_B);
        case (k)
            `PDR_KIND_DIR, `PDR_KIND_DRIVE, `PDR_KIND_PIN_IN,
            `PDR_KIND_OUT_DATA: regExists = anyPort;
            `PDR_KIND_CTRL: regExists = (p == `PDR_PORT_E)
                || (p == `PDR_PORT_F) || (p == `PDR_PORT_G);
            `PDR_KIND_OMC, `PDR_KIND_MASK: regExists = ab;
            `PDR_KIND_IMC: regExists = ab || (p == `PDR_PORT_C);
            `PDR_KIND_ENOUT: regExists = ab || (p == `PDR_PORT_C)
                || (p == `PDR_PORT_F);
            default: regExists = 1'b0;
        endcase
    endfunction

    // one register decode shared by both macrocell banks
    function automatic logic regHit(input logic [4:0] k, input logic [2:0] p,
                                    input logic [4:0] wantK,
                                    input logic [2:0] wantP);
        regHit = (k == wantK) && (p == wantP);
    endfunction

    always_comb begin
        // kind sits above the three port bits of the offset
        kind = mcuReq.addr[7:3];
        port = mcuReq.addr[2:0];
        // a high select pin shuts the whole register space
        memSpaceEnable = !(cfg.pd2IsChipSel
            && pinIn[`PDR_PORT_D][`PDR_PD_CHIPSEL]);
        accessOk = mcuReq.sel && memSpaceEnable;
        regPresent = regExists(kind, port);
        wrOk = accessOk && mcuReq.wr && regPresent;
        // refused and unmapped writes fall through without effect
        omcLoadA = wrOk
            && regHit(kind, port, `PDR_KIND_OMC, `PDR_PORT_A);
        omcLoadB = wrOk
            && regHit(kind, port, `PDR_KIND_OMC, `PDR_PORT_B);
        commonClockTick = cfg.pd1IsClock
            && pinIn[`PDR_PORT_D][`PDR_PD_CLOCK] && !state.clkPrev;
        addressStrobe = cfg.pd0IsStrobe
            && pinIn[`PDR_PORT_D][`PDR_PD_STROBE];
        dataByteEnable = cfg.pd3IsByteEn
            && pinIn[`PDR_PORT_D][`PDR_PD_BYTE_EN];
    end

    pdr_macrocell_bank bankA (
        .core_clk(core_clk),
        .resetn(resetn),
        .clockTick(commonClockTick),
        .pldNext(pldMcellNextA),
        .mcuLoad(omcLoadA),
        .mcuData(mcuReq.wdata),
        .loadMask(state.mask[0]),
        .q(mcellA)
    );

    pdr_macrocell_bank bankB (
        .core_clk(core_clk),
        .resetn(resetn),
        .clockTick(commonClockTick),
        .pldNext(pldMcellNextB),
        .mcuLoad(omcLoadB),
        .mcuData(mcuReq.wdata),
        .loadMask(state.mask[1]),
        .q(mcellB)
    );

    // per-port function steering in front of the pin drivers
    always_comb begin
        altData = '0;
        altSel = '0;
        oeEff = '0;
        dataEff = state.outData;
        dirEff = state.dir;
        for (int i = 0; i < `PDR_NUM_PORTS; i++) begin
            openDrainEff[i] = state.drive[i];
        end
        // slew ports never sink-only; their drive bits go to slew outputs
        openDrainEff[`PDR_PORT_C] = '0;
        openDrainEff[`PDR_PORT_F] = '0;
        oeEff[`PDR_PORT_A] = pldOeTerm[`PDR_PORT_A];
        oeEff[`PDR_PORT_B] = pldOeTerm[`PDR_PORT_B];
        oeEff[`PDR_PORT_C] = pldOeTerm[`PDR_PORT_C];
        oeEff[`PDR_PORT_F] = pldOeTerm[`PDR_PORT_F];
        altData[`PDR_PORT_A] = mcellA;
        altSel[`PDR_PORT_A] = {8{cfg.portAMcellOut}};
        altData[`PDR_PORT_B] = mcellB;
        altSel[`PDR_PORT_B] = {8{cfg.portBMcellOut}};
        altData[`PDR_PORT_C] = chipSelects;
        altSel[`PDR_PORT_C] = {8{cfg.portCChipSelOut}};
        dirEff[`PDR_PORT_D] = state.dir[`PDR_PORT_D] & `PDR_PORT_D_MASK;
        openDrainEff[`PDR_PORT_D] = state.drive[`PDR_PORT_D]
            & `PDR_PORT_D_MASK;
        altData[`PDR_PORT_E] = state.addrLatch;
        altSel[`PDR_PORT_E] = state.ctrl[`PDR_PORT_E];
        // port g offers only the latched address as an alternate
        altData[`PDR_PORT_G] = state.addrLatch;
        altSel[`PDR_PORT_G] = state.ctrl[`PDR_PORT_G];
        // battery pins override the direction bits
        batMask = '0;
        if (cfg.pe6IsBattery) begin
            dirEff[`PDR_PORT_E][`PDR_PE_BAT_IN] = 1'b0;
        end
        if (cfg.pe7IsBatteryFlag) begin
            batMask[`PDR_PE_BAT_FLAG] = 1'b1;
            dirEff[`PDR_PORT_E][`PDR_PE_BAT_FLAG] = 1'b1;
            altData[`PDR_PORT_E][`PDR_PE_BAT_FLAG] = vccBelowBattery;
        end
        altSel[`PDR_PORT_E] = altSel[`PDR_PORT_E] | batMask;
        // port f: data port beats chip selects beats latched address
        if (cfg.portFDataPort) begin
            altData[`PDR_PORT_F] = hostDataOut;
            altSel[`PDR_PORT_F] = `PDR_FULL_MASK;
            dirEff[`PDR_PORT_F] = '0;
            oeEff[`PDR_PORT_F] = {8{hostDataOe}};
        end else if (cfg.portFChipSelOut) begin
            altData[`PDR_PORT_F] = chipSelects;
            altSel[`PDR_PORT_F] = `PDR_FULL_MASK;
        end else begin
            altData[`PDR_PORT_F] = state.addrLatch;
            altSel[`PDR_PORT_F] = state.ctrl[`PDR_PORT_F];
        end
    end

    for (genvar g = 0; g < `PDR_NUM_PORTS; g++) begin : gPort
        pdr_pin_driver #(
            .WIDTH(8)
        ) driver (
            .dataOut(dataEff[g]),
            .altData(altData[g]),
            .altSel(altSel[g]),
            .dirBits(dirEff[g]),
            .oeTerm(oeEff[g]),
            .openDrain(openDrainEff[g]),
            .pinLevel(drvLevel[g]),
            .pinOe(drvOe[g]),
            .enableStatus(enStatus[g])
        );
    end

    // read multiplexer for the addressed register
    always_comb begin
        readValue = `PDR_RESET_BYTE;
        case (kind)
            `PDR_KIND_DIR: begin
                readValue = state.dir[port];
            end
            `PDR_KIND_DRIVE: begin
                readValue = state.drive[port];
            end
            `PDR_KIND_CTRL: begin
                readValue = state.ctrl[port];
            end
            `PDR_KIND_PIN_IN: begin
                readValue = pinIn[port];
            end
            `PDR_KIND_OUT_DATA: begin
                readValue = state.outData[port];
            end
            `PDR_KIND_OMC: begin
                readValue = (port == `PDR_PORT_A) ? mcellA : mcellB;
            end
            `PDR_KIND_MASK: begin
                readValue = state.mask[port[0]];
            end
            `PDR_KIND_IMC: begin
                readValue = state.input_macrocell[port[1:0]];
            end
            `PDR_KIND_ENOUT: begin
                readValue = enStatus[port];
            end
            default: readValue = `PDR_RESET_BYTE;
        endcase
        // port d upper nibble has no pins behind it
        readValue = readValue & portMask(port);
        if (!regPresent) begin
            readValue = `PDR_RESET_BYTE;
        end
    end

    always_comb begin
        next_state = state;
        next_state.clkPrev = pinIn[`PDR_PORT_D][`PDR_PD_CLOCK];
        next_state.rdValid = 1'b0;
        if (wrOk) begin
            case (kind)
                `PDR_KIND_DIR: begin
                    next_state.dir[port] = mcuReq.wdata & portMask(port);
                end
                `PDR_KIND_DRIVE: begin
                    next_state.drive[port] = mcuReq.wdata & portMask(port);
                end
                `PDR_KIND_CTRL: begin
                    next_state.ctrl[port] = mcuReq.wdata;
                end
                `PDR_KIND_OUT_DATA: begin
                    next_state.outData[port] = mcuReq.wdata
                        & portMask(port);
                end
                `PDR_KIND_MASK: begin
                    next_state.mask[port[0]] = mcuReq.wdata;
                end
                default: begin
                    next_state.rdValid = 1'b0;
                end
            endcase
        end
        // input macrocells sample on the common clock only
        if (commonClockTick) begin
            next_state.input_macrocell[0] = pinIn[`PDR_PORT_A];
            next_state.input_macrocell[1] = pinIn[`PDR_PORT_B];
            next_state.input_macrocell[2] = pinIn[`PDR_PORT_C];
        end
        if (addressStrobe) begin
            next_state.addrLatch = hostAddrLow;
        end
        // rdData keeps its value between reads
        if (accessOk && mcuReq.rd) begin
            next_state.rdData = readValue;
            next_state.rdValid = 1'b1;
        end
    end

    // clkPrev starts low, so a clock pin held high through reset ticks once
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        mcuRdData = state.rdData;
        mcuRdValid = state.rdValid;
        pinDrv.level = drvLevel;
        pinDrv.oe = drvOe;
        pinDrv.level[`PDR_PORT_D][7:4] = '0;
        pinDrv.oe[`PDR_PORT_D][7:4] = '0;
        pinDrv.level[`PDR_PORT_G + 1'b0] = drvLevel[`PDR_PORT_G];
        pldInputBus.imcA = state.input_macrocell[0];
        pldInputBus.imcB = state.input_macrocell[1];
        pldInputBus.imcC = state.input_macrocell[2];
        pldInputBus.mcellA = mcellA;
        pldInputBus.mcellB = mcellB;
        pldInputBus.portD = pinIn[`PDR_PORT_D][3:0];
        pldInputBus.portF = pinIn[`PDR_PORT_F];
        hostDataIn = pinIn[`PDR_PORT_F];
        slewFastC = state.drive[`PDR_PORT_C];
        slewFastF = state.drive[`PDR_PORT_F];
    end
endmodule

/* dv/pdr_port_chk.sv */
`timescale 1ns/1ps
module pdr_port_chk (
    input wire logic core_clk,
    input wire logic resetn,
    input wire pdr_pkg::pdr_mcu_req_s mcuReq,
    input wire logic [7:0] mcuRdData,
    input wire logic mcuRdValid,
    input wire pdr_pkg::pdr_cfg_s cfg,
    input wire pdr_pkg::pdr_bytes_t pinIn,
    input wire logic [7:0] pldMcellNextA,
    input wire pdr_pkg::pdr_pld_in_s pldInputBus,
    input wire logic [7:0] hostDataIn,
    input wire logic addressStrobe,
    input wire logic dataByteEnable,
    input wire logic commonClockTick,
    input wire logic memSpaceEnable
);
    import pdr_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_read_answer: assert property (mcuRdValid ==
        $past(mcuReq.sel && mcuReq.rd && memSpaceEnable))
        else $error("read answer mismatch");
    a_rdata_holds: assert property (!mcuRdValid |-> $stable(mcuRdData))
        else $error("read data moved without a read");
    a_select_gate: assert property (memSpaceEnable ==
        !(cfg.pd2IsChipSel && pinIn[3][2]))
        else $error("chip select gating wrong");
    a_strobe_pass: assert property (addressStrobe ==
        (cfg.pd0IsStrobe && pinIn[3][0])) else $error("strobe wrong");
    a_byte_enable: assert property (dataByteEnable ==
        (cfg.pd3IsByteEn && pinIn[3][3])) else $error("byte enable wrong");
    a_port_d_direct: assert property (pldInputBus.portD == pinIn[3][3:0])
        else $error("port d pld input wrong");
    a_port_f_direct: assert property (pldInputBus.portF == pinIn[5]
        && hostDataIn == pinIn[5]) else $error("port f input wrong");
    a_imc_capture: assert property (commonClockTick |=>
        pldInputBus.imcA == $past(pinIn[0]) &&
        pldInputBus.imcB == $past(pinIn[1]) &&
        pldInputBus.imcC == $past(pinIn[2])) else $error("imc capture wrong");
    a_mcell_tick: assert property (commonClockTick && !(mcuReq.sel &&
        mcuReq.wr && mcuReq.addr == 8'h28) |=>
        pldInputBus.mcellA == $past(pldMcellNextA))
        else $error("macrocell tick load wrong");
    a_tick_pulse: assert property (commonClockTick |->
        cfg.pd1IsClock ##1 !commonClockTick) else $error("tick not a pulse");
endmodule
bind pdr_port pdr_port_chk chk_u (.core_clk(core_clk), .resetn(resetn),
    .mcuReq(mcuReq), .mcuRdData(mcuRdData), .mcuRdValid(mcuRdValid),
    .cfg(cfg), .pinIn(pinIn), .pldMcellNextA(pldMcellNextA),
    .pldInputBus(pldInputBus), .hostDataIn(hostDataIn),
    .addressStrobe(addressStrobe), .dataByteEnable(dataByteEnable),
    .commonClockTick(commonClockTick), .memSpaceEnable(memSpaceEnable));

/* dv/pdr_pin_model.sv */
`timescale 1ns/1ps
module pdr_pin_model (
    input wire pdr_pkg::pdr_pins_s pinDrv,
    input wire pdr_pkg::pdr_bytes_t ext,
    output pdr_pkg::pdr_bytes_t pinIn
);
    import pdr_pkg::*;
    // released pins follow the outside source, never the stale drive
    always_comb begin
        pinIn = (pinDrv.level & pinDrv.oe) | (ext & ~pinDrv.oe);
    end
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import pdr_pkg::*;
    logic core_clk, resetn, mcuRdValid, addressStrobe, dataByteEnable;
    logic commonClockTick, memSpaceEnable, hostDataOe, vccBelowBattery;
    logic [7:0] mcuRdData, hostDataIn, slewFastC, slewFastF, hostAddrLow;
    pdr_mcu_req_s mcuReq;
    pdr_cfg_s cfg;
    pdr_bytes_t pinIn, ext, pldOeTerm;
    pdr_pins_s pinDrv;
    pdr_pld_in_s pldInputBus;
    int n_fail, checked;
    pdr_port dut_u (.core_clk(core_clk), .resetn(resetn), .mcuReq(mcuReq),
        .mcuRdData(mcuRdData), .mcuRdValid(mcuRdValid), .cfg(cfg),
        .pinIn(pinIn), .pinDrv(pinDrv), .pldOeTerm(pldOeTerm),
        .pldMcellNextA(8'h5a), .pldMcellNextB(8'ha5), .chipSelects(8'hc3),
        .hostAddrLow(hostAddrLow), .hostDataOut(8'h81),
        .hostDataOe(hostDataOe), .vccBelowBattery(vccBelowBattery),
        .pldInputBus(pldInputBus), .hostDataIn(hostDataIn),
        .addressStrobe(addressStrobe), .dataByteEnable(dataByteEnable),
        .commonClockTick(commonClockTick), .memSpaceEnable(memSpaceEnable),
        .slewFastC(slewFastC), .slewFastF(slewFastF));
    pdr_pin_model pin_u (.pinDrv(pinDrv), .ext(ext), .pinIn(pinIn));
    function automatic logic [7:0] ad(input int k, input int p);
        return 8'(k * 8 + p);
    endfunction
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one access every two cycles keeps a clear edge between requests
    task acc(input logic w, r, input logic [7:0] a, d, input logic v,
             input logic [7:0] e);
        @(posedge core_clk);
        mcuReq <= {1'b1, w, r, a, d};
        @(posedge core_clk);
        mcuReq <= '0;
        #1;
        if (r) chk("rdValid", {7'h00, v}, {7'h00, mcuRdValid});
        if (r && v) chk("rdData", e, mcuRdData);
    endtask
    task wr(input logic [7:0] a, d);
        acc(1'b1, 1'b0, a, d, 1'b0, 8'h00);
    endtask
    task rd(input logic [7:0] a, e);
        acc(1'b0, 1'b1, a, 8'h00, 1'b1, e);
    endtask
    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task tally_and_finish;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        n_fail++;
        $display("ERROR watchdog expected done seen hang");
        tally_and_finish;
    end
    initial begin
        resetn = 0; mcuReq = '0; cfg = '0; ext = '0; pldOeTerm = '0;
        hostAddrLow = 8'h00; hostDataOe = 0; vccBelowBattery = 0;
        n_fail = 0; checked = 0;
        repeat (6) @(posedge core_clk);
        resetn <= 1;
        for (int p = 0; p < 7; p++) begin
            rd(ad(0, p), 8'h00);
            rd(ad(1, p), 8'h00);
            rd(ad(4, p), 8'h00);
        end
        for (int p = 4; p < 7; p++) rd(ad(2, p), 8'h00);
        rd(ad(6, 0), 8'h00); rd(ad(6, 1), 8'h00);
        rd(ad(8, 0), 8'h00); rd(ad(8, 5), 8'h00);
        @(posedge core_clk); ext[0] <= 8'haa;
        wr(ad(4, 0), 8'h55); wr(ad(0, 0), 8'h0f);
        rd(ad(4, 0), 8'h55);
        chk("oeA", 8'h0f, pinDrv.oe[0]);
        chk("levelA", 8'h05, pinDrv.level[0] & 8'h0f);
        rd(ad(3, 0), 8'ha5);
        rd(ad(8, 0), 8'h0f);
        @(posedge core_clk); pldOeTerm[0] <= 8'hf0;
        step(2); chk("oeA", 8'hff, pinDrv.oe[0]);
        rd(ad(8, 0), 8'hff);
        wr(ad(0, 3), 8'hff); rd(ad(0, 3), 8'h0f);
        // release port d again so its dedicated inputs follow ext
        wr(ad(0, 3), 8'h00);
        wr(ad(5, 2), 8'h77); rd(ad(5, 2), 8'h00); rd(ad(7, 3), 8'h00);
        wr(ad(6, 0), 8'hf0); wr(ad(5, 0), 8'hff); wr(ad(5, 1), 8'h3c);
        rd(ad(6, 0), 8'hf0); rd(ad(5, 0), 8'h0f);
        rd(ad(5, 1), 8'h3c);
        @(posedge core_clk); cfg.pd1IsClock <= 1'b1; ext[2] <= 8'h96;
        @(posedge core_clk); ext[3][1] <= 1'b1;
        step(4); rd(ad(7, 2), 8'h96);
        rd(ad(7, 0), 8'h55); rd(ad(5, 0), 8'h5a);
        rd(ad(5, 1), 8'ha5);
        @(posedge core_clk); cfg.portAMcellOut <= 1; cfg.portCChipSelOut <= 1;
        wr(ad(0, 2), 8'hff);
        chk("levelA", 8'h5a, pinDrv.level[0]);
        chk("levelC", 8'hc3, pinDrv.level[2]);
        wr(ad(0, 1), 8'hff); wr(ad(1, 1), 8'hff); wr(ad(4, 1), 8'hf0);
        chk("oeB", 8'h0f, pinDrv.oe[1]);
        chk("levelB", 8'h00, pinDrv.level[1]);
        rd(ad(8, 1), 8'hff);
        wr(ad(1, 2), 8'h33); chk("slewC", 8'h33, slewFastC);
        wr(ad(1, 5), 8'h44);
        chk("slewF", 8'h44, slewFastF);
        @(posedge core_clk); cfg.pd2IsChipSel <= 1; ext[3][2] <= 1'b1;
        wr(ad(0, 6), 8'h11);
        acc(1'b0, 1'b1, ad(0, 6), 8'h00, 1'b0, 8'h00);
        @(posedge core_clk); ext[3][2] <= 1'b0;
        rd(ad(0, 6), 8'h00);
        @(posedge core_clk); cfg.pe7IsBatteryFlag <= 1; vccBelowBattery <= 1;
        step(2); chk("oeE7", 8'h01, {7'h00, pinDrv.oe[4][7]});
        chk("levelE7", 8'h01, {7'h00, pinDrv.level[4][7]});
        @(posedge core_clk); vccBelowBattery <= 0;
        step(2); chk("levelE7", 8'h00, {7'h00, pinDrv.level[4][7]});
        @(posedge core_clk); cfg.pe7IsBatteryFlag <= 0; cfg.pd0IsStrobe <= 1;
        cfg.pd3IsByteEn <= 1; hostAddrLow <= 8'h7e; ext[3] <= 8'h09;
        wr(ad(2, 4), 8'hff); wr(ad(0, 4), 8'hff);
        @(posedge core_clk); ext[3] <= 8'h00; hostAddrLow <= 8'h11;
        step(2); chk("levelE", 8'h7e, pinDrv.level[4]);
        @(posedge core_clk);
        cfg.portFChipSelOut <= 1;
        step(2);
        chk("levelF", 8'hc3, pinDrv.level[5]);
        @(posedge core_clk); cfg.portFDataPort <= 1; hostDataOe <= 1;
        step(2); chk("levelF", 8'h81, pinDrv.level[5]);
        chk("oeF", 8'hff, pinDrv.oe[5]);
        tally_and_finish;
    end
endmodule
